//--- verilog/isolated_io_pkg.sv
package isolated_io_pkg;

    // ------------------------------------------------------------
    // register map, byte offsets on the 16-bit local bus
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_OUTPUT_LATCH  = 4'h0;
    localparam logic [3:0] OFF_INPUT_STATE   = 4'h2;
    localparam logic [3:0] OFF_CONTROL       = 4'h4;
    localparam logic [3:0] OFF_RISE_ENABLE   = 4'h6;
    localparam logic [3:0] OFF_FALL_ENABLE   = 4'h8;
    localparam logic [3:0] OFF_RISE_PENDING  = 4'ha;
    localparam logic [3:0] OFF_FALL_PENDING  = 4'hc;
    localparam logic [3:0] OFF_FILTER_IVAL   = 4'he;

    // ------------------------------------------------------------
    // control register fields and reset values
    // ------------------------------------------------------------
    localparam int         CTL_GLOBAL_IRQ_ON = 0;
    localparam int         CTL_GUARD_ON      = 1;
    localparam int         CTL_FILTER_ON     = 2;
    localparam int         CTL_GUARD_TRIP    = 3;
    localparam logic [15:0] RST_WORD         = 16'h0000;
    localparam logic       RST_BIT           = 1'b0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int         MCLK_KHZ          = 50000;
    localparam int         GUARD_TIMEOUT_MS  = 120;
    localparam int         GUARD_CYCLES_DEF  = GUARD_TIMEOUT_MS * MCLK_KHZ;
    localparam int         GUARD_CNT_W       = 23;
    localparam int         FILTER_PRESCALE   = 64;
    localparam int         PRESCALE_W        = 6;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 6'h3f;
    localparam int         FILTER_CNT_W      = 19;

    // ------------------------------------------------------------
    // local bus request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } loc_req_t;

endpackage

//--- verilog/line_filter.sv
`timescale 1ns/1ps

module line_filter
    import isolated_io_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    senseLine,
    input  wire logic                    filterOn,
    input  wire logic                    tick,
    input  wire logic [FILTER_CNT_W-1:0] threshold,
    output logic                         accepted
);

    // ------------------------------------------------------------
    // stability counter
    // ------------------------------------------------------------
    logic [FILTER_CNT_W-1:0] stableCount;
    logic                    differs;
    logic                    reached;

    assign differs = senseLine != accepted;
    assign reached = (stableCount + 1'b1) >= threshold;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            accepted    <= RST_BIT;
            stableCount <= '0;
        end
        else if (!filterOn || !differs)
        begin
            accepted    <= senseLine;
            stableCount <= '0;
        end
        else if (tick && reached)
        begin
            accepted    <= senseLine;
            stableCount <= '0;
        end
        else if (tick)
        begin
            stableCount <= stableCount + 1'b1;
        end
    end

endmodule

//--- verilog/isolated_digital_io_controller.sv
`timescale 1ns/1ps

// How it works
// - output latch bit n drives output line n+1; one means active
// - reset clears the output latch, all lines inactive
// - watchdog arms on first latch write after its enable bit is set
// - any read or write of the output latch restarts the timeout
// - armed watchdog expiring after 120 ms blanks outputs, sets flag, locks latch
// - latch writes are ignored while the watchdog lock stands
// - writing one to control bit 3 clears the flag and the lock
// - after unlock outputs stay off until the next latch write
// - reset leaves the watchdog disabled
// - the trip flag can only rise while the watchdog is enabled
// - one programmable filter interval serves all sixteen inputs
// - with filtering on, an edge needs a stable interval, up to 63 clocks short, to count
// - reset disables filtering and zeroes the interval value
// - input register shows the sixteen accepted inputs, read only
// - input interrupts need global enable plus the per-line edge enable
// - reset clears global and all per-line edge enables
// - control holds trip, filter, guard and irq enables in bits 3..0
// - interrupts leave on one active-low pin
// - pending bits read one when set, clear on write one
// - pending bit n belongs to input line n+1 in both registers
// - filter interval is a 16-bit read/write value reset to zero
// - filter time is (value+1) times 64 clocks times about 3.5

module isolated_digital_io_controller
    import isolated_io_pkg::*;
#(
    parameter int LINES        = 16,
    parameter int GUARD_CYCLES = GUARD_CYCLES_DEF
)
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire loc_req_t         locReq,
    output logic [15:0]           locRdata,
    output logic                  locAck,
    input  wire logic [LINES-1:0] senseLine,
    output logic [LINES-1:0]      driveLine,
    output logic                  intA_n
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic hits(input loc_req_t r, input logic [3:0] off);
        hits = (r.wr || r.rd) && (r.addr == off);
    endfunction

    logic latchAccess;
    logic latchWrite;
    logic ctrlWrite;
    logic riseEnWrite;
    logic fallEnWrite;
    logic risePendWrite;
    logic fallPendWrite;
    logic filterWrite;

    assign latchAccess   = hits(locReq, OFF_OUTPUT_LATCH);
    assign latchWrite    = locReq.wr && hits(locReq, OFF_OUTPUT_LATCH);
    assign ctrlWrite     = locReq.wr && hits(locReq, OFF_CONTROL);
    assign riseEnWrite   = locReq.wr && hits(locReq, OFF_RISE_ENABLE);
    assign fallEnWrite   = locReq.wr && hits(locReq, OFF_FALL_ENABLE);
    assign risePendWrite = locReq.wr && hits(locReq, OFF_RISE_PENDING);
    assign fallPendWrite = locReq.wr && hits(locReq, OFF_FALL_PENDING);
    assign filterWrite   = locReq.wr && hits(locReq, OFF_FILTER_IVAL);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0]            outputLatch;
    logic                   outputsBlank;
    logic                   globalIrqOn;
    logic                   guardOn;
    logic                   filterOn;
    logic                   guardTripFlag;
    logic                   guardArmed;
    logic [GUARD_CNT_W-1:0] guardCount;
    logic [LINES-1:0]       riseEnable;
    logic [LINES-1:0]       fallEnable;
    logic [LINES-1:0]       risePending;
    logic [LINES-1:0]       fallPending;
    logic [15:0]            filterIntervalValue;
    logic [LINES-1:0]       accepted;
    logic [LINES-1:0]       acceptedPrev;
    logic [PRESCALE_W-1:0]  prescale;

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    logic tripEvent;
    logic tripClear;
    logic next_guardOn;

    assign next_guardOn = ctrlWrite ? locReq.wdata[CTL_GUARD_ON] : guardOn;
    assign tripEvent    = guardArmed && guardOn && !latchAccess
                          && guardCount == GUARD_CNT_W'(GUARD_CYCLES - 1);
    assign tripClear    = (ctrlWrite && locReq.wdata[CTL_GUARD_TRIP]) || !guardOn;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            guardCount <= '0;
        else if (!guardArmed || latchAccess)
            guardCount <= '0;
        else
            guardCount <= guardCount + 1'b1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            guardArmed <= RST_BIT;
        else if (!guardOn || tripEvent)
            guardArmed <= 1'b0;
        else if (latchWrite && !guardTripFlag)
            guardArmed <= 1'b1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            guardTripFlag <= RST_BIT;
        else if (tripEvent)
            guardTripFlag <= 1'b1;
        else if (tripClear)
            guardTripFlag <= 1'b0;
    end

    // ------------------------------------------------------------
    // output latch and drive
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            outputLatch  <= RST_WORD;
            outputsBlank <= RST_BIT;
        end
        else if (tripEvent)
            outputsBlank <= 1'b1;
        else if (latchWrite && !guardTripFlag)
        begin
            outputLatch  <= locReq.wdata;
            outputsBlank <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            driveLine <= '0;
        else
            driveLine <= outputLatch[LINES-1:0] & ~{LINES{outputsBlank}};
    end

    // ------------------------------------------------------------
    // control and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            globalIrqOn <= RST_BIT;
            guardOn     <= RST_BIT;
            filterOn    <= RST_BIT;
        end
        else if (ctrlWrite)
        begin
            globalIrqOn <= locReq.wdata[CTL_GLOBAL_IRQ_ON];
            guardOn     <= next_guardOn;
            filterOn    <= locReq.wdata[CTL_FILTER_ON];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            riseEnable          <= '0;
            fallEnable          <= '0;
            filterIntervalValue <= RST_WORD;
        end
        else
        begin
            if (riseEnWrite)
                riseEnable <= locReq.wdata[LINES-1:0];
            if (fallEnWrite)
                fallEnable <= locReq.wdata[LINES-1:0];
            if (filterWrite)
                filterIntervalValue <= locReq.wdata;
        end
    end

    // ------------------------------------------------------------
    // input filtering
    // ------------------------------------------------------------
    logic                    tick;
    logic [FILTER_CNT_W:0]   scaled;
    logic [FILTER_CNT_W-1:0] threshold;

    assign tick      = prescale == PRESCALE_LAST;
    assign scaled    = (FILTER_CNT_W + 1)'(({3'h0, filterIntervalValue} + 1'b1) * 3'h7);
    assign threshold = scaled[FILTER_CNT_W:1];

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            prescale <= '0;
        else
            prescale <= prescale + 1'b1;
    end

    generate
        for (genvar i = 0; i < LINES; i++)
        begin : g_line
            line_filter u_filter (
                .mclk      (mclk),
                .rst       (rst),
                .senseLine (senseLine[i]),
                .filterOn  (filterOn),
                .tick      (tick),
                .threshold (threshold),
                .accepted  (accepted[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // edge pending and interrupt pin
    // ------------------------------------------------------------
    logic [LINES-1:0] riseSet;
    logic [LINES-1:0] fallSet;
    logic [LINES-1:0] riseClr;
    logic [LINES-1:0] fallClr;

    assign riseSet = accepted & ~acceptedPrev & riseEnable;
    assign fallSet = ~accepted & acceptedPrev & fallEnable;
    assign riseClr = risePendWrite ? locReq.wdata[LINES-1:0] : '0;
    assign fallClr = fallPendWrite ? locReq.wdata[LINES-1:0] : '0;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            acceptedPrev <= '0;
            risePending  <= '0;
            fallPending  <= '0;
        end
        else
        begin
            acceptedPrev <= accepted;
            risePending  <= (risePending & ~riseClr) | riseSet;
            fallPending  <= (fallPending & ~fallClr) | fallSet;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            intA_n <= 1'b1;
        else
            intA_n <= !(globalIrqOn && |(risePending | fallPending));
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [15:0] readMux;

    always_comb
    begin
        case (locReq.addr)
            OFF_OUTPUT_LATCH: readMux = outputLatch;
            OFF_INPUT_STATE:  readMux = 16'(accepted);
            OFF_CONTROL:      readMux = {12'h000, guardTripFlag, filterOn,
                                         guardOn, globalIrqOn};
            OFF_RISE_ENABLE:  readMux = 16'(riseEnable);
            OFF_FALL_ENABLE:  readMux = 16'(fallEnable);
            OFF_RISE_PENDING: readMux = 16'(risePending);
            OFF_FALL_PENDING: readMux = 16'(fallPending);
            OFF_FILTER_IVAL:  readMux = filterIntervalValue;
            default:          readMux = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            locRdata <= 16'h0000;
            locAck   <= 1'b0;
        end
        else
        begin
            locRdata <= locReq.rd ? readMux : 16'h0000;
            locAck   <= locReq.rd || locReq.wr;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    AST_TRIP_BLANKS: assert property ($rose(guardTripFlag) |=> driveLine == '0)
        else $error("outputs not off after watchdog trip");

    AST_ARM_NEEDS_WRITE: assert property ($rose(guardArmed)
        |-> $past(guardOn && latchWrite))
        else $error("watchdog armed without enable and latch write");

    AST_RESTART: assert property (latchAccess |=> guardCount == '0)
        else $error("latch access did not restart watchdog");

    AST_LOCK_IGNORES: assert property (guardTripFlag && latchWrite
        |=> outputLatch == $past(outputLatch))
        else $error("latch written while locked");

    AST_CLEAR_TRIP: assert property (ctrlWrite && locReq.wdata[3]
        && !tripEvent |=> !guardTripFlag)
        else $error("trip flag not cleared by write one");

    AST_STAY_OFF: assert property (outputsBlank && !latchWrite
        |=> outputsBlank ##1 driveLine == '0)
        else $error("outputs released without a latch write");

    AST_TRIP_NEEDS_ENABLE: assert property ($rose(guardTripFlag)
        |-> $past(guardOn))
        else $error("trip flag rose with watchdog disabled");

    AST_RAW_PASS: assert property (!filterOn |=> accepted == $past(senseLine))
        else $error("unfiltered input not passed through");

    AST_IRQ_PIN: assert property (globalIrqOn && |(risePending | fallPending)
        |=> !intA_n)
        else $error("interrupt pin not asserted");

    AST_IRQ_QUIET: assert property (!globalIrqOn |=> intA_n)
        else $error("interrupt pin asserted with global enable off");

    AST_W1C: assert property (risePendWrite
        |=> (risePending & $past(riseClr & ~riseSet)) == '0)
        else $error("pending bit not cleared by write one");

    COV_TRIP: cover property (guardArmed ##1 guardTripFlag ##[1:50] !guardTripFlag);
    COV_RISE_IRQ: cover property (|riseSet ##2 !intA_n);
    COV_FALL_IRQ: cover property (|fallSet ##2 !intA_n);
    COV_FILTERED: cover property (filterOn && tick ##1 |(accepted ^ acceptedPrev));

endmodule

//--- testbench/local_bus_host.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// host side of the local register bus
// ------------------------------------------------------------
module local_bus_host
    import isolated_io_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [15:0] locRdata,
    input  wire logic        locAck,
    output loc_req_t         locReq
);
    initial locReq = '{wr: 1'b0, rd: 1'b0, addr: 4'h1, wdata: 16'h0000};

    // one-cycle strobe; released lines show junk, not the last value
    task automatic access(input logic isWr, input logic [3:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic ack);
        @(posedge mclk);
        locReq <= '{wr: isWr, rd: ~isWr, addr: a, wdata: d};
        @(posedge mclk);
        locReq <= '{wr: 1'b0, rd: 1'b0, addr: a ^ 4'h1, wdata: ~d};
        @(negedge mclk);
        ack = locAck;
        q   = locRdata;
    endtask
endmodule

//--- testbench/isolated_digital_io_controller_test.sv
`timescale 1ns/1ps

module isolated_digital_io_controller_test
    import isolated_io_pkg::*;
;
    localparam int GUARD = 200;
    localparam int LIMIT = 20000;

    logic        mclk;
    logic        rst       = 1'b1;
    loc_req_t    locReq;
    logic [15:0] locRdata;
    logic        locAck;
    logic [15:0] senseLine = 16'h0000;
    logic [15:0] driveLine;
    logic        intA_n;
    int          nErrors   = 0;
    int          checked   = 0;
    int          cycles    = 0;

    // ------------------------------------------------------------
    // clock, design and host
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    isolated_digital_io_controller #(.LINES(16), .GUARD_CYCLES(GUARD)) dut_u (
        .mclk      (mclk),
        .rst       (rst),
        .locReq    (locReq),
        .locRdata  (locRdata),
        .locAck    (locAck),
        .senseLine (senseLine),
        .driveLine (driveLine),
        .intA_n    (intA_n)
    );

    local_bus_host hostU (
        .mclk     (mclk),
        .locRdata (locRdata),
        .locAck   (locAck),
        .locReq   (locReq)
    );

    // ------------------------------------------------------------
    // checks and bus tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checked, nErrors);
        if (nErrors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic checkWord(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            nErrors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp)
        begin
            nErrors++;
            $display("MISMATCH at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic        ack;
        hostU.access(1'b1, a, d, q, ack);
        checkBit(ack, 1'b1, "write ack");
    endtask

    task automatic rdCheck(input logic [3:0] a, input logic [15:0] exp, input string what);
        logic [15:0] q;
        logic        ack;
        hostU.access(1'b0, a, 16'h0000, q, ack);
        checkBit(ack, 1'b1, "read ack");
        checkWord(q, exp, what);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic setSense(input logic [15:0] v);
        @(posedge mclk);
        senseLine <= v;
    endtask

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            nErrors++;
            $display("MISMATCH at %0t: run did not finish", $time);
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        idle(1);
        checkWord(driveLine, 16'h0000, "outputs after reset");
        checkBit(intA_n, 1'b1, "irq pin after reset");
        rdCheck(OFF_OUTPUT_LATCH, 16'h0000, "latch reset");
        rdCheck(OFF_CONTROL, 16'h0000, "control reset");
        rdCheck(OFF_RISE_ENABLE, 16'h0000, "rise enable reset");
        rdCheck(OFF_FALL_ENABLE, 16'h0000, "fall enable reset");
        rdCheck(OFF_RISE_PENDING, 16'h0000, "rise pending reset");
        rdCheck(OFF_FALL_PENDING, 16'h0000, "fall pending reset");
        rdCheck(OFF_FILTER_IVAL, 16'h0000, "interval reset");
        rdCheck(4'h1, 16'h0000, "unmapped read");
        $display("test reset done");

        wr(OFF_OUTPUT_LATCH, 16'h8001);
        idle(1);
        checkWord(driveLine, 16'h8001, "outputs follow latch");
        rdCheck(OFF_OUTPUT_LATCH, 16'h8001, "latch readback");
        wr(OFF_INPUT_STATE, 16'hffff);
        rdCheck(OFF_INPUT_STATE, 16'h0000, "input write ignored");
        wr(OFF_RISE_ENABLE, 16'ha5c3);
        wr(OFF_FALL_ENABLE, 16'h5a3c);
        wr(OFF_FILTER_IVAL, 16'hfffe);
        rdCheck(OFF_RISE_ENABLE, 16'ha5c3, "rise enable rw");
        rdCheck(OFF_FALL_ENABLE, 16'h5a3c, "fall enable rw");
        rdCheck(OFF_FILTER_IVAL, 16'hfffe, "interval rw");
        wr(OFF_CONTROL, 16'hfff7);
        rdCheck(OFF_CONTROL, 16'h0007, "control fields");
        wr(OFF_CONTROL, 16'h0000);
        $display("test registers done");

        wr(OFF_RISE_ENABLE, 16'h0001);
        wr(OFF_FALL_ENABLE, 16'h8000);
        wr(OFF_CONTROL, 16'h0001);
        setSense(16'h8001);
        idle(5);
        rdCheck(OFF_INPUT_STATE, 16'h8001, "input lines");
        rdCheck(OFF_RISE_PENDING, 16'h0001, "rise pending");
        checkBit(intA_n, 1'b0, "irq pin asserted");
        setSense(16'h0000);
        idle(5);
        rdCheck(OFF_FALL_PENDING, 16'h8000, "fall pending");
        wr(OFF_RISE_PENDING, 16'h0001);
        rdCheck(OFF_RISE_PENDING, 16'h0000, "rise pending cleared");
        wr(OFF_FALL_PENDING, 16'h7fff);
        rdCheck(OFF_FALL_PENDING, 16'h8000, "zero writes keep pending");
        wr(OFF_CONTROL, 16'h0000);
        idle(2);
        checkBit(intA_n, 1'b1, "global enable gates pin");
        wr(OFF_FALL_PENDING, 16'h8000);
        rdCheck(OFF_FALL_PENDING, 16'h0000, "fall pending cleared");
        $display("test interrupts done");

        // interval 1: accepted between 384 and 448 clocks after a change
        wr(OFF_FILTER_IVAL, 16'h0001);
        wr(OFF_CONTROL, 16'h0004);
        setSense(16'h0104);
        idle(100);
        setSense(16'h0000);
        idle(100);
        rdCheck(OFF_INPUT_STATE, 16'h0000, "glitch rejected");
        setSense(16'h0104);
        idle(370);
        rdCheck(OFF_INPUT_STATE, 16'h0000, "too early");
        idle(140);
        rdCheck(OFF_INPUT_STATE, 16'h0104, "accepted after interval");
        wr(OFF_CONTROL, 16'h0000);
        $display("test filter done");

        wr(OFF_CONTROL, 16'h0002);
        idle(GUARD + 20);
        rdCheck(OFF_CONTROL, 16'h0002, "not armed before latch write");
        checkWord(driveLine, 16'h8001, "outputs kept unarmed");
        wr(OFF_OUTPUT_LATCH, 16'h00ff);
        repeat (2)
        begin
            idle(GUARD - 50);
            rdCheck(OFF_OUTPUT_LATCH, 16'h00ff, "latch read restarts");
            idle(GUARD - 50);
            wr(OFF_OUTPUT_LATCH, 16'h00ff);
        end
        rdCheck(OFF_CONTROL, 16'h0002, "no trip while serviced");
        checkWord(driveLine, 16'h00ff, "outputs while serviced");
        idle(GUARD + 20);
        checkWord(driveLine, 16'h0000, "outputs off on trip");
        rdCheck(OFF_CONTROL, 16'h000a, "trip flag set");
        wr(OFF_OUTPUT_LATCH, 16'h0f0f);
        idle(2);
        checkWord(driveLine, 16'h0000, "locked outputs");
        rdCheck(OFF_OUTPUT_LATCH, 16'h00ff, "locked latch");
        wr(OFF_CONTROL, 16'h000a);
        rdCheck(OFF_CONTROL, 16'h0002, "trip flag cleared");
        idle(2);
        checkWord(driveLine, 16'h0000, "off after unlock");
        wr(OFF_OUTPUT_LATCH, 16'h0f0f);
        idle(1);
        checkWord(driveLine, 16'h0f0f, "drive after unlock write");
        wr(OFF_CONTROL, 16'h0000);
        idle(GUARD + 20);
        rdCheck(OFF_CONTROL, 16'h0000, "no flag when disabled");
        checkWord(driveLine, 16'h0f0f, "outputs kept disabled");
        $display("test watchdog done");
        give_verdict();
    end
endmodule
